// File: relay_line_consts.vh
// Constants for the relay terminal line controller.
`ifndef RELAY_LINE_CONSTS_VH
`define RELAY_LINE_CONSTS_VH
`define CLK_MHZ            100
`define TIMEOUT_SEC        10
`define TIMEOUT_CYCLES     (`TIMEOUT_SEC * `CLK_MHZ * 1000000)
`define REG_CTRL           4'h0
`define REG_STATUS         4'h1
`define REG_IRQ_STAT       4'h2
`define REG_IRQ_MASK       4'h3
`define REG_DATA           4'h4
`define REG_LINES          4'h5
`define CTRL_READ_BIT      0
`define CTRL_WCTL_BIT      1
`define CTRL_DEV_LSB       4
`define CTRL_ABORT_BIT     8
`define DEV_DATA_MODE      2'h0
`define DEV_ACK            2'h1
`define DEV_NAK            2'h2
`define DEV_ATTEND         2'h3
`define IRQ_SREQ_BIT       0
`define IRQ_CHAR_BIT       1
`define IRQ_DONE_BIT       2
`define IRQ_ERR_BIT        3
`define CHAR_DEPTH_LOG2    4
`endif

// File: char_store.v
// Small character memory with registered read data.
`default_nettype none
module char_store (
  input  wire       clk,
  input  wire       we,
  input  wire [3:0] waddr,
  input  wire [6:0] wdata,
  input  wire [3:0] raddr,
  output reg  [6:0] rdata
);
  reg [6:0] mem [0:15];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // char_store
`default_nettype wire

// File: relay_line_ctrl.v
// Channel controller for a shared cable of relay data transmitters.
// Overview of operation
// - Talk with exactly one transmitter at a time; never take two concurrently.
// - Check each received character for odd parity; record error status on failure.
// - Send a releasing reply outside attendance mode; none in attendance mode.
// - Host command sets attendance for all; first character may mark one transaction.
// - Each outgoing control line comes from its own flip-flop.
// - A falling edge on the service-request line is a service request.
// - Attendance line high in attendance mode, low in data mode.
// - Negative reply clears the negative line; positive reply sets the positive line.
// - Transmitter uses the line only while enable is asserted.
// - Report request to host, wait for read instruction, then assert enable.
// - Drop enable drive when data arrives, then watch enable for the end drop.
// - Data inputs are inverted: energised line reads as zero.
// - Control write device 0 data mode, 1 ack, 2 nak, 3 attendance.
// - End read on second drop in attendance mode, first drop in data mode.
// - Ten-second timer from read start; expiry sets error and ends transfer.
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`default_nettype none
`include "relay_line_consts.vh"
module relay_line_ctrl #(
  parameter [31:0] TIMEOUT_CYC = `TIMEOUT_CYCLES
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire        irq,
  input  wire        sreq_line_in,
  input  wire        enable_line_in,
  input  wire [6:0]  data_lines_n,
  input  wire        data_strobe,
  output reg         attend_line_q,
  output reg         nak_line_q,
  output reg         ack_line_q,
  output reg         enable_line_q
);
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_GRANT = 2'h1;
  localparam [1:0] ST_RECV  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  reg        sreq_s1_q, sreq_s2_q, sreq_s3_q;
  reg        en_s1_q, en_s2_q, en_s3_q;
  reg        stb_s1_q, stb_s2_q, stb_s3_q;
  reg [6:0]  data_s1_q, data_s2_q;
  reg [1:0]  state_q;
  reg        busy_q;
  reg        error_q;
  reg        txn_attend_q;
  reg        first_char_q;
  reg [1:0]  line_drop_counter;
  reg [31:0] timer_q;
  reg [3:0]  irq_stat_q;
  reg [3:0]  irq_mask_q;
  reg [3:0]  wr_ptr_q;
  reg [3:0]  rd_ptr_q;
  reg [4:0]  count_q;
  reg        rd_pend_q;
  wire [6:0] mem_rdata;
  wire [6:0] rx_char;
  wire       sreq_fall;
  wire       en_fall;
  wire       char_in;
  wire       bus_wr;
  wire       bus_rd;
  wire       parity_ok;
  wire       attend_now;
  wire       pop;

  function odd_parity;
    input [6:0] c;
    begin
      odd_parity = ^c;
    end
  endfunction

  function sel;
    input [3:0] a;
    input [3:0] reg_id;
    begin
      sel = (a == reg_id);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Every cable input passes two flops before use.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sreq_s1_q <= 1'b1;
      sreq_s2_q <= 1'b1;
      sreq_s3_q <= 1'b1;
      en_s1_q   <= 1'b0;
      en_s2_q   <= 1'b0;
      en_s3_q   <= 1'b0;
      stb_s1_q  <= 1'b0;
      stb_s2_q  <= 1'b0;
      stb_s3_q  <= 1'b0;
      data_s1_q <= 7'h7F;
      data_s2_q <= 7'h7F;
    end else begin
      sreq_s1_q <= sreq_line_in;
      sreq_s2_q <= sreq_s1_q;
      sreq_s3_q <= sreq_s2_q;
      en_s1_q   <= enable_line_in;
      en_s2_q   <= en_s1_q;
      en_s3_q   <= en_s2_q;
      stb_s1_q  <= data_strobe;
      stb_s2_q  <= stb_s1_q;
      stb_s3_q  <= stb_s2_q;
      data_s1_q <= data_lines_n;
      data_s2_q <= data_s1_q;
    end
  end

  assign sreq_fall = sreq_s3_q & ~sreq_s2_q;
  assign en_fall   = en_s3_q & ~en_s2_q;
  assign rx_char   = ~data_s2_q;
  // Only the one granted transmitter can be heard, and only while granting or receiving.
  assign char_in   = stb_s2_q & ~stb_s3_q & ((state_q == ST_GRANT) | (state_q == ST_RECV));
  assign parity_ok = odd_parity(rx_char);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: writes complete at once, reads take one wait cycle.
  assign bus_wr          = avs_write;
  assign bus_rd          = avs_read & rd_pend_q;
  assign avs_waitrequest = avs_read & ~rd_pend_q;
  assign pop             = bus_rd & sel(avs_address, `REG_DATA) & (count_q != 5'h00);
  // The first character selects attendance for just this transaction.
  assign attend_now      = attend_line_q | txn_attend_q;
  assign irq             = |(irq_stat_q & irq_mask_q);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_pend_q    <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_pend_q <= avs_read & ~rd_pend_q;
      if (avs_read & ~rd_pend_q) begin
        case (avs_address)
          `REG_STATUS:   avs_readdata <= {22'h0, count_q, error_q, busy_q, state_q, 1'b0};
          `REG_DATA:     avs_readdata <= {24'h0, (count_q != 5'h00), mem_rdata};
          `REG_IRQ_STAT: avs_readdata <= {28'h0, irq_stat_q};
          `REG_IRQ_MASK: avs_readdata <= {28'h0, irq_mask_q};
          `REG_LINES:    avs_readdata <= {27'h0, enable_line_q, ack_line_q, nak_line_q,
                                          attend_line_q, txn_attend_q};
          default:       avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character store, pointers and occupancy.
  char_store u_store (
    .clk   (clk),
    .we    (char_in & (count_q != 5'h10)),
    .waddr (wr_ptr_q),
    .wdata (rx_char),
    .raddr (rd_ptr_q),
    .rdata (mem_rdata)
  );

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q  <= 5'h00;
    end else begin
      if (char_in & (count_q != 5'h10)) begin
        wr_ptr_q <= wr_ptr_q + 4'h1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end
      if ((char_in & (count_q != 5'h10)) & ~pop) begin
        count_q <= count_q + 5'h01;
      end else if (pop & ~(char_in & (count_q != 5'h10))) begin
        count_q <= count_q - 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequence and control-line flip-flops.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q           <= ST_IDLE;
      busy_q            <= 1'b0;
      error_q           <= 1'b0;
      txn_attend_q      <= 1'b0;
      first_char_q      <= 1'b0;
      line_drop_counter <= 2'h0;
      timer_q           <= 32'h0000_0000;
      attend_line_q     <= 1'b0;
      nak_line_q        <= 1'b0;
      ack_line_q        <= 1'b0;
      enable_line_q     <= 1'b0;
    end else begin
      if (bus_wr & sel(avs_address, `REG_CTRL) & avs_writedata[`CTRL_WCTL_BIT]) begin
        case (avs_writedata[`CTRL_DEV_LSB +: 2])
          `DEV_DATA_MODE: attend_line_q <= 1'b0;
          `DEV_ACK:       ack_line_q    <= 1'b1;
          `DEV_NAK:       nak_line_q    <= 1'b0;
          `DEV_ATTEND:    attend_line_q <= 1'b1;
          default:        attend_line_q <= attend_line_q;
        endcase
      end
      // The first character may arrive while still granting, so it is handled here.
      if (char_in) begin
        first_char_q <= 1'b0;
        if (!parity_ok) begin
          error_q <= 1'b1;
        end
        if (first_char_q) begin
          txn_attend_q <= rx_char[6];
        end
      end
      case (state_q)
        ST_IDLE: begin
          if (bus_wr & sel(avs_address, `REG_CTRL) & avs_writedata[`CTRL_READ_BIT]) begin
            // Reply lines return to rest for the new transaction.
            ack_line_q        <= 1'b0;
            nak_line_q        <= 1'b1;
            enable_line_q     <= 1'b1;
            busy_q            <= 1'b1;
            error_q           <= 1'b0;
            txn_attend_q      <= 1'b0;
            first_char_q      <= 1'b1;
            line_drop_counter <= 2'h0;
            timer_q           <= TIMEOUT_CYC;
            state_q           <= ST_GRANT;
          end
        end
        ST_GRANT: begin
          timer_q <= timer_q - 32'h0000_0001;
          if (char_in | stb_s2_q) begin
            enable_line_q <= 1'b0;
            state_q       <= ST_RECV;
          end else if (timer_q == 32'h0000_0001) begin
            enable_line_q <= 1'b0;
            error_q       <= 1'b1;
            busy_q        <= 1'b0;
            state_q       <= ST_IDLE;
          end
        end
        ST_RECV: begin
          timer_q <= timer_q - 32'h0000_0001;
          enable_line_q <= 1'b0;
          if (timer_q == 32'h0000_0001) begin
            error_q           <= 1'b1;
            busy_q            <= 1'b0;
            line_drop_counter <= 2'h0;
            state_q           <= ST_IDLE;
          end else if (en_fall) begin
            if (!attend_now || line_drop_counter == 2'h1) begin
              line_drop_counter <= 2'h0;
              busy_q            <= 1'b0;
              state_q           <= ST_IDLE;
            end else begin
              line_drop_counter <= line_drop_counter + 2'h1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      if (bus_wr & sel(avs_address, `REG_CTRL) & avs_writedata[`CTRL_ABORT_BIT]) begin
        enable_line_q <= 1'b0;
        busy_q        <= 1'b0;
        state_q       <= ST_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events: set wins over a write-one clear in the same cycle.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
    end else begin
      if (bus_wr & sel(avs_address, `REG_IRQ_MASK)) begin
        irq_mask_q <= avs_writedata[3:0];
      end
      irq_stat_q <= (irq_stat_q &
                     ~((bus_wr & sel(avs_address, `REG_IRQ_STAT)) ? avs_writedata[3:0] : 4'h0))
                    | {(char_in & ~parity_ok) | (busy_q & (timer_q == 32'h0000_0001)),
                       busy_q & ~busy_n_q_unused(state_q),
                       char_in,
                       sreq_fall & (state_q == ST_IDLE)};
    end
  end

  function busy_n_q_unused;
    input [1:0] s;
    begin
      busy_n_q_unused = (s != ST_IDLE);
    end
  endfunction
endmodule // relay_line_ctrl
`default_nettype wire

// File: relay_line_asserts.sv
// Concurrent checks on the relay line channel ports.
`default_nettype none
`include "relay_line_consts.vh"
module relay_line_asserts #(
  parameter [31:0] TIMEOUT_CYC = 200
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        data_strobe,
  input wire logic        attend_line_q,
  input wire logic        nak_line_q,
  input wire logic        ack_line_q,
  input wire logic        enable_line_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic       ctl = avs_write && avs_address == `REG_CTRL;
  wire logic       wctl = ctl && avs_writedata[`CTRL_WCTL_BIT];
  wire logic [1:0] dev = avs_writedata[5:4];
  chk_reset_quiet: assert property (
    $rose(rstn) |-> !(attend_line_q | nak_line_q | ack_line_q | enable_line_q))
    else $error("line active at reset release");
  chk_dev_data: assert property (wctl && dev == `DEV_DATA_MODE |=> !attend_line_q)
    else $error("data mode did not clear attend");
  chk_dev_attend: assert property (wctl && dev == `DEV_ATTEND |=> attend_line_q)
    else $error("attendance did not set attend");
  chk_dev_ack: assert property (wctl && dev == `DEV_ACK |=> ack_line_q)
    else $error("ack reply not driven");
  chk_dev_nak: assert property (wctl && dev == `DEV_NAK |=> !nak_line_q)
    else $error("nak reply not driven");
  chk_ack_cause: assert property ($rose(ack_line_q) |-> $past(wctl && dev == `DEV_ACK))
    else $error("ack rose without command");
  chk_attend_cause: assert property (
    $rose(attend_line_q) |-> $past(wctl && dev == `DEV_ATTEND))
    else $error("attend rose without command");
  chk_grant_cause: assert property (
    $rose(enable_line_q) |-> $past(ctl && avs_writedata[`CTRL_READ_BIT]))
    else $error("enable rose without read start");
  chk_enable_drop: assert property (
    enable_line_q && $rose(data_strobe) |-> ##[1:6] !enable_line_q)
    else $error("enable kept after data arrived");
endmodule // relay_line_asserts
bind relay_line_ctrl relay_line_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) relay_line_asserts_inst (
  .clk, .rstn, .avs_address, .avs_write, .avs_writedata, .data_strobe,
  .attend_line_q, .nak_line_q, .ack_line_q, .enable_line_q);
`default_nettype wire

// File: relay_cable_model.sv
// Model of one relay transmitter on the shared cable.
`default_nettype none
module relay_cable_model (
  input wire logic       clk,
  input wire logic       enable_line_q,
  input wire logic       ack_line_q,
  input wire logic       nak_line_q,
  output var logic       sreq_line_in,
  output wire logic      enable_line_in,
  output var logic [6:0] data_lines_n,
  output var logic       data_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic conn = 1'b0;
  logic drop = 1'b0;
  // Once connected the transmitter itself keeps the enable line powered.
  assign enable_line_in = (enable_line_q | conn) & !drop;
  initial begin
    sreq_line_in = 1'b1;
    data_lines_n = 7'h7F;
    data_strobe  = 1'b0;
  end
  // Only one requester is modelled, so priority is trivially lowest first.
  task automatic send(input logic [27:0] w, input int n, input bit att);
    int i;
    @(posedge clk) sreq_line_in <= 1'b0;
    wait (enable_line_q);
    @(posedge clk) conn <= 1'b1;
    for (i = 0; i < n; i++) begin
      repeat (20 + $urandom % 20) @(posedge clk);
      data_lines_n <= ~w[i*7+:7];
      data_strobe  <= 1'b1;
      repeat (4) @(posedge clk);
      data_strobe  <= 1'b0;
      data_lines_n <= 7'h7F;
    end
    if (!att) @(posedge ack_line_q or negedge nak_line_q);
    @(posedge clk) drop <= 1'b1;
    repeat (3) @(posedge clk);
    if (att) begin
      drop <= 1'b0;
      repeat (3) @(posedge clk);
      drop <= 1'b1;
      repeat (3) @(posedge clk);
    end
    conn         <= 1'b0;
    sreq_line_in <= 1'b1;
    @(posedge clk) drop <= 1'b0;
  endtask
endmodule // relay_cable_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the relay line channel.
`default_nettype none
`include "relay_line_consts.vh"
`define CK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  wire logic   avs_waitrequest, irq, sreq_line_in, enable_line_in, data_strobe;
  wire logic   attend_line_q, nak_line_q, ack_line_q, enable_line_q;
  wire logic [6:0] data_lines_n;
  int mismatches = 0, checks = 0;
  always #5 clk = ~clk;
  relay_line_ctrl #(.TIMEOUT_CYC(1000)) relay_line_ctrl_inst (.clk, .rstn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq,
    .sreq_line_in, .enable_line_in, .data_lines_n, .data_strobe, .attend_line_q,
    .nak_line_q, .ack_line_q, .enable_line_q);
  relay_cable_model relay_cable_model_inst (.clk, .enable_line_q, .ack_line_q, .nak_line_q,
    .sreq_line_in, .enable_line_in, .data_lines_n, .data_strobe);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    avs_address   <= a;
    avs_writedata <= v;
    avs_write     <= 1'b1;
    do @(posedge clk); while (avs_waitrequest);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest);
    v = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic poll(input logic [3:0] a, input logic [31:0] m, v);
    logic [31:0] r;
    for (int i = 0; i < 3000; i++) begin
      rd(a, r);
      if ((r & m) === v) break;
    end
    `CK(r & m, v)
  endtask
  // Odd parity lives in bit 4; bad forces even parity.
  function automatic logic [6:0] mk(input logic b6, input logic [5:0] r, input logic bad);
    mk = {b6, r[5], 1'b0, r[3:0]};
    mk[4] = ~(^mk) ^ bad;
  endfunction
  task automatic msg(input int n, input bit att, input bit bad, input bit b6);
    logic [27:0] w;
    logic [31:0] r;
    w = '0;
    for (int i = 0; i < n; i++) w[i*7+:7] = mk(b6 && i == 0, 6'($urandom), bad && i == n-1);
    wr(`REG_IRQ_MASK, 32'h0);
    fork
      relay_cable_model_inst.send(w, n, att);
      begin
        poll(`REG_IRQ_STAT, 32'h1, 32'h1);
        `CK(irq, 1'b0)
        `CK(enable_line_q, 1'b0)
        wr(`REG_IRQ_MASK, 32'hF);
        `CK(irq, 1'b1)
        wr(`REG_IRQ_STAT, 32'hF);
        `CK(irq, 1'b0)
        wr(`REG_CTRL, 32'h1);
        if (!att) begin
          poll(`REG_STATUS, 32'h3E0, 32'(n) << 5);
          wr(`REG_CTRL, bad ? 32'h22 : 32'h12);
        end
        poll(`REG_STATUS, 32'h8, 32'h0);
      end
    join
    rd(`REG_IRQ_STAT, r);
    `CK(r[3], bad)
    wr(`REG_IRQ_STAT, 32'hF);
    for (int i = 0; i < n; i++) begin
      rd(`REG_DATA, r);
      `CK(r[7:0], {1'b1, w[i*7+:7]})
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial begin
    logic [2:0]  e;
    logic [31:0] r;
    void'($urandom(42));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CK({attend_line_q, nak_line_q, ack_line_q, enable_line_q}, 4'h0)
    rd(4'hF, r);
    `CK(r, 32'h0)
    e = 3'b000;
    for (int d = 0; d < 4; d++) begin
      wr(`REG_CTRL, 32'h2 | (32'(d) << 4));
      e = (d == 0) ? e & 3'b110 : (d == 1) ? e | 3'b100 : (d == 2) ? e & 3'b101 : e | 3'b001;
      `CK({ack_line_q, nak_line_q, attend_line_q}, e)
      rd(`REG_LINES, r);
      `CK(r[3:1], e)
    end
    msg(3, 1, 0, 0);
    wr(`REG_CTRL, 32'h2);
    msg(2, 1, 0, 1);
    repeat (3) msg(1 + $urandom % 4, 0, 0, 0);
    msg(2, 0, 1, 0);
    wr(`REG_CTRL, 32'h1);
    repeat (100) @(posedge clk);
    rd(`REG_STATUS, r);
    `CK(r[3], 1'b1)
    poll(`REG_STATUS, 32'h8, 32'h0);
    rd(`REG_IRQ_STAT, r);
    `CK(r[3], 1'b1)
    complete_run();
  end
endmodule // testbench
`default_nettype wire
